/* device_control_upper_bits.sv */
// Upper control bits of the device control register with PHY pin control.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Behaviour
// RL1: Software writes zero to reserved bit 18.
// RL2: Override bit 16 hands the PHY power pin to software.
// RL3: With override set, the power pin follows bit 17.
// RL4: Power-down request clear lets internal logic choose PHY power-down.
// RL5: Request plus extended power-down enable puts the PHY into power-down.
// RL6: Commanded power-down also cuts PHY supply through the power pin unless override bit 16 is set.
// RL7: Writing bit 25 pulses the management interrupt, then clears.
// RL8: Writing bit 26 resets the data path, then clears.
// RL9: Bit 27 enables receive pause; negotiation loads it.
// RL10: Bit 28 enables transmit pause; negotiation loads it.
// RL11: Bit 30 enables VLAN tag insertion on flagged descriptors.
// RL12: Bit 30 enables VLAN tag stripping on receive.
// RL13: Bit 31 drives the PHY reset line, self-clearing.
// RL14: PHY reset acts only when the permit bit is one.
// RL15: PHY reset also reinitialises the PHY serial link.
// RL16: Software sets host reset in the same write as PHY reset.
// RL17: Software keeps PHY reset asserted at least 1 ms; here bit 31 self-clears and the line is high for one clock.
// RL18: Self-clearing bits read zero after their action is launched.
module device_control_upper_bits
   import devctl_pkg::*;
#(
   parameter int PULSE_LEN = PULSE_CYCLES
) (
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   input  wire logic        clk_en_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   input  wire logic        ext_powerdown_enable_in,
   input  wire logic        internal_powerdown_in,
   input  wire logic        internal_pin_level_in,
   input  wire logic        autoneg_load_in,
   input  wire logic        autoneg_rx_pause_in,
   input  wire logic        autoneg_tx_pause_in,
   output logic             phy_power_pin_out,
   output logic             phy_powerdown_out,
   output logic             host_to_mgmt_interrupt_out,
   output logic             host_software_reset_out,
   output logic             phy_reset_line_out,
   output logic             phy_serial_link_init_out,
   output mac_ctl_t         mac_ctl_out
);

   if (PULSE_LEN < 1 || PULSE_LEN > 255) begin : gen_len_check
      $error("PULSE_LEN out of range");
   end

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction : addr_hit

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   bus_req_t    req;
   logic [31:0] ctrl;
   logic        phy_reset_permit;
   logic [7:0]  sw_cnt;
   logic [7:0]  irq_cnt;
   logic        phy_rst_req;
   logic        link_init;

   assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   wire         ctrl_wr    = req.wr && addr_hit(req.addr, CTRL_OFFSET);
   wire         sema_wr    = req.wr && addr_hit(req.addr, SEMA_OFFSET);
   wire         wr_irq     = ctrl_wr && req.wdata[POS_MGMT_IRQ];
   wire         wr_host_software_reset   = ctrl_wr && req.wdata[POS_SW_RESET];
   wire         wr_phyrst  = ctrl_wr && req.wdata[POS_PHY_RST] && phy_reset_permit; // RL14
   wire [31:0]  next_ctrl  = (ctrl & ~CTRL_WMASK) | (req.wdata & CTRL_WMASK);
   wire         sw_active  = (sw_cnt != 8'h00);
   wire         irq_active = (irq_cnt != 8'h00);
   wire [7:0]   next_sw_cnt  = wr_host_software_reset ? 8'(PULSE_LEN) : // RL8
                               (sw_active ? sw_cnt - 8'h01 : sw_cnt);
   wire [7:0]   next_irq_cnt = wr_irq ? 8'(PULSE_LEN) : // RL7
                               (irq_active ? irq_cnt - 8'h01 : irq_cnt);

   wire [31:0]  state_word = {25'h0, link_init, phy_rst_req, sw_active, irq_active,
                              phy_powerdown_out, phy_power_pin_out, phy_reset_line_out};

   wire [31:0]  next_rdata = addr_hit(req.addr, CTRL_OFFSET)  ? ctrl :
                             addr_hit(req.addr, SEMA_OFFSET)  ? {31'h0, phy_reset_permit} :
                             addr_hit(req.addr, STATE_OFFSET) ? state_word : 32'h0000_0000;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctrl <= CTRL_RESET;
      end else if (clk_en_in) begin
         if (ctrl_wr) begin
            ctrl <= next_ctrl; // RL18
         end else if (autoneg_load_in) begin
            ctrl[POS_RX_PAUSE] <= autoneg_rx_pause_in; // RL9
            ctrl[POS_TX_PAUSE] <= autoneg_tx_pause_in; // RL10
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         phy_reset_permit <= 1'b0;
      end else if (clk_en_in && sema_wr) begin
         phy_reset_permit <= req.wdata[POS_PERMIT];
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (clk_en_in) begin
         rdata_out <= req.rd ? next_rdata : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Self-clearing actions
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         sw_cnt <= 8'h00;
      end else if (clk_en_in) begin
         sw_cnt <= next_sw_cnt; // RL8
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         irq_cnt <= 8'h00;
      end else if (clk_en_in) begin
         irq_cnt <= next_irq_cnt; // RL7
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         phy_rst_req <= 1'b0;
         link_init   <= 1'b0;
      end else if (clk_en_in) begin
         phy_rst_req <= wr_phyrst; // RL13
         link_init   <= wr_phyrst; // RL15
      end
   end

   // ----------------------------------------------------------------
   // Outputs to the PHY and MAC
   // ----------------------------------------------------------------
   wire pd_cmd = ctrl[POS_PD_REQ] && ext_powerdown_enable_in; // RL5

   assign phy_powerdown_out          = ctrl[POS_PD_REQ] ? pd_cmd : internal_powerdown_in; // RL4
   assign phy_power_pin_out          = ctrl[POS_PIN_OVR] ? ctrl[POS_PIN_LEVEL] : // RL2 RL3
                                       (pd_cmd ? 1'b0 : internal_pin_level_in); // RL6
   assign host_to_mgmt_interrupt_out = irq_active;
   assign host_software_reset_out    = sw_active;
   assign phy_reset_line_out         = phy_rst_req;
   assign phy_serial_link_init_out   = link_init;
   assign mac_ctl_out                = '{pause_rx: ctrl[POS_RX_PAUSE], // RL9
                                         pause_tx: ctrl[POS_TX_PAUSE], // RL10
                                         vlan:     ctrl[POS_VLAN]}; // RL11 RL12

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   pin_override_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL3
      ctrl[POS_PIN_OVR] |-> phy_power_pin_out == ctrl[POS_PIN_LEVEL])
      else $error("Power pin ignores override level.");

   pin_internal_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL2
      !ctrl[POS_PIN_OVR] && !pd_cmd |-> phy_power_pin_out == internal_pin_level_in)
      else $error("Power pin ignores internal level.");

   pd_internal_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL4
      !ctrl[POS_PD_REQ] |-> phy_powerdown_out == internal_powerdown_in)
      else $error("Power-down not from internal logic.");

   pd_forced_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL5
      ctrl[POS_PD_REQ] && ext_powerdown_enable_in |-> phy_powerdown_out)
      else $error("Power-down request not obeyed.");

   pd_supply_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL6
      pd_cmd && !ctrl[POS_PIN_OVR] |-> !phy_power_pin_out)
      else $error("Supply not cut on power-down.");

   irq_pulse_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL7
      clk_en_in && wr_irq |=> host_to_mgmt_interrupt_out)
      else $error("Management interrupt not raised.");

   host_software_reset_pulse_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL8
      clk_en_in && wr_host_software_reset |=> host_software_reset_out)
      else $error("Host reset not raised.");

   phy_gate_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL14
      clk_en_in && ctrl_wr && !phy_reset_permit |=> !phy_reset_line_out)
      else $error("PHY reset without permit.");

   phy_link_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL15
      phy_reset_line_out |-> phy_serial_link_init_out)
      else $error("Serial link not reinitialised.");

   self_clear_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL18
      clk_en_in && ctrl_wr |=> !ctrl[POS_PHY_RST] && !ctrl[POS_SW_RESET] && !ctrl[POS_MGMT_IRQ])
      else $error("Self-clearing bit held.");

   pause_load_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL9
      clk_en_in && autoneg_load_in && !ctrl_wr |=>
      mac_ctl_out.pause_rx == $past(autoneg_rx_pause_in))
      else $error("Negotiated pause not loaded.");

   pause_tx_load_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL10
      clk_en_in && autoneg_load_in && !ctrl_wr |=>
      mac_ctl_out.pause_tx == $past(autoneg_tx_pause_in))
      else $error("Negotiated transmit pause not loaded.");

   pause_write_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL9
      clk_en_in && ctrl_wr |=> mac_ctl_out.pause_rx == $past(wdata_in[POS_RX_PAUSE]))
      else $error("Receive pause write lost.");

   vlan_write_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL11
      clk_en_in && ctrl_wr |=> mac_ctl_out.vlan == $past(wdata_in[POS_VLAN]))
      else $error("VLAN enable write lost.");

   pin_level_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL3
      clk_en_in && ctrl_wr && wdata_in[POS_PIN_OVR] |=>
      phy_power_pin_out == $past(wdata_in[POS_PIN_LEVEL]))
      else $error("Power pin misses written level.");

   pd_release_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL5
      ctrl[POS_PD_REQ] && !ext_powerdown_enable_in |-> !phy_powerdown_out)
      else $error("Power-down without enable.");

   irq_restart_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL7
      clk_en_in && wr_irq |=> irq_cnt == 8'(PULSE_LEN))
      else $error("Interrupt count not restarted.");

   irq_end_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL7
      clk_en_in && irq_cnt == 8'h01 && !wr_irq |=> !host_to_mgmt_interrupt_out)
      else $error("Management interrupt not cleared.");

   host_software_reset_restart_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL8
      clk_en_in && wr_host_software_reset |=> sw_cnt == 8'(PULSE_LEN))
      else $error("Host reset count not restarted.");

   host_software_reset_end_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL8
      clk_en_in && sw_cnt == 8'h01 && !wr_host_software_reset |=> !host_software_reset_out)
      else $error("Host reset not cleared.");

   phy_rst_set_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL13
      clk_en_in && wr_phyrst |=> phy_reset_line_out)
      else $error("PHY reset not raised.");

   phy_rst_clear_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL13
      clk_en_in && !wr_phyrst |=> !phy_reset_line_out)
      else $error("PHY reset not cleared.");

   link_set_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL15
      clk_en_in && wr_phyrst |=> phy_serial_link_init_out)
      else $error("Serial link init not raised.");

   permit_hold_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL14
      phy_reset_line_out |-> $past(phy_reset_permit))
      else $error("PHY reset raised without permit.");

   sema_write_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL14
      clk_en_in && sema_wr |=> phy_reset_permit == $past(wdata_in[POS_PERMIT]))
      else $error("Permit write lost.");

   sema_read_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL14
      clk_en_in && rd_in && addr_hit(addr_in, SEMA_OFFSET) |=>
      rdata_out == {31'h0, $past(phy_reset_permit)})
      else $error("Permit read wrong.");

   state_read_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL13
      clk_en_in && rd_in && addr_hit(addr_in, STATE_OFFSET) |=>
      rdata_out[0] == $past(phy_reset_line_out))
      else $error("State read wrong.");

   rdata_ctrl_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL18
      clk_en_in && rd_in && addr_hit(addr_in, CTRL_OFFSET) |=> rdata_out == $past(ctrl))
      else $error("Control read wrong.");

   read_clear_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL18
      clk_en_in && rd_in |=>
      !rdata_out[POS_MGMT_IRQ] && !rdata_out[POS_SW_RESET] && !rdata_out[POS_PHY_RST])
      else $error("Self-clearing bit read as one.");

   rsvd_hold_a: assert property (@(posedge clock_in) disable iff (srst_in) // RL18
      (ctrl & ~CTRL_WMASK) == (CTRL_RESET & ~CTRL_WMASK))
      else $error("Fixed control bit changed.");

   rdata_idle_a: assert property (@(posedge clock_in) disable iff (srst_in)
      clk_en_in && !rd_in |=> rdata_out == 32'h0000_0000)
      else $error("Read data outside read cycle.");

   unmapped_read_a: assert property (@(posedge clock_in) disable iff (srst_in)
      clk_en_in && rd_in && !addr_hit(addr_in, CTRL_OFFSET) && !addr_hit(addr_in, SEMA_OFFSET)
      && !addr_hit(addr_in, STATE_OFFSET) |=> rdata_out == 32'h0000_0000)
      else $error("Unmapped read not zero.");

   freeze_ctrl_a: assert property (@(posedge clock_in) disable iff (srst_in)
      !clk_en_in |=> ctrl == $past(ctrl))
      else $error("Control changed while frozen.");

   freeze_count_a: assert property (@(posedge clock_in) disable iff (srst_in)
      !clk_en_in |=> irq_cnt == $past(irq_cnt) && sw_cnt == $past(sw_cnt))
      else $error("Pulse count changed while frozen.");

   freeze_reset_a: assert property (@(posedge clock_in) disable iff (srst_in)
      !clk_en_in |=> phy_reset_line_out == $past(phy_reset_line_out))
      else $error("PHY reset changed while frozen.");

endmodule : device_control_upper_bits

/* devctl_pkg.sv */
// Package with the register map, field positions and timing counts of the control block.
package devctl_pkg;

   localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
   localparam logic [7:0]  SEMA_OFFSET     = 8'h04;
   localparam logic [7:0]  STATE_OFFSET    = 8'h08;
   localparam int          POS_PIN_OVR     = 16;
   localparam int          POS_PIN_LEVEL   = 17;
   localparam int          POS_RSVD18      = 18;
   localparam int          POS_PD_REQ      = 24;
   localparam int          POS_MGMT_IRQ    = 25;
   localparam int          POS_SW_RESET    = 26;
   localparam int          POS_RX_PAUSE    = 27;
   localparam int          POS_TX_PAUSE    = 28;
   localparam int          POS_VLAN        = 30;
   localparam int          POS_PHY_RST     = 31;
   localparam int          POS_PERMIT      = 0;
   localparam logic [31:0] CTRL_RESET      = 32'h0010_0000;
   localparam logic [31:0] CTRL_WMASK      = 32'h5903_0000;
   localparam int          PULSE_NS        = 16;
   localparam int          CLK_MHZ         = 250;
   localparam int          PULSE_CYCLES    = (PULSE_NS * CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef struct packed {
      logic pause_rx;
      logic pause_tx;
      logic vlan;
   } mac_ctl_t;

endpackage : devctl_pkg

/* phy_model.sv */
// Behavioural PHY that counts its reset pulses and tracks its supply state.
`timescale 1ns/1ps
module phy_model (
   input  wire logic       clock_in,
   input  wire logic       power_pin_in,
   input  wire logic       powerdown_in,
   input  wire logic       reset_line_in,
   input  wire logic       link_init_in,
   output logic [7:0]      resets_out,
   output logic            powered_out
);
   // ----------------------------------------
   // Reset counting and supply state
   // ----------------------------------------
   initial resets_out = 8'h00;
   always @(posedge clock_in) begin
      if (reset_line_in && link_init_in) begin
         resets_out <= resets_out + 8'h01;
      end
   end
   assign powered_out = power_pin_in && !powerdown_in;
endmodule : phy_model

/* device_control_upper_bits_tb.sv */
// Self-checking testbench of the upper device control bits.
`timescale 1ns/1ps
module device_control_upper_bits_tb;
   import devctl_pkg::*;
   logic        clock_in, srst_in, wr, rd, ext_pd, int_pd, int_lvl, an_ld, an_rx, an_tx;
   logic        pin, pd, irq, swr, prst, link, pwr, en;
   logic [7:0]  addr, resets;
   logic [31:0] wdata, rdata, d;
   mac_ctl_t    mac;
   int          mismatches, checked;
   integer      n1, n2, n3;
   device_control_upper_bits dut (.clock_in(clock_in), .srst_in(srst_in), .clk_en_in(en),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .ext_powerdown_enable_in(ext_pd), .internal_powerdown_in(int_pd),
      .internal_pin_level_in(int_lvl), .autoneg_load_in(an_ld), .autoneg_rx_pause_in(an_rx),
      .autoneg_tx_pause_in(an_tx), .phy_power_pin_out(pin), .phy_powerdown_out(pd),
      .host_to_mgmt_interrupt_out(irq), .host_software_reset_out(swr),
      .phy_reset_line_out(prst), .phy_serial_link_init_out(link), .mac_ctl_out(mac));
   phy_model phy (.clock_in(clock_in), .power_pin_in(pin), .powerdown_in(pd),
      .reset_line_in(prst), .link_init_in(link), .resets_out(resets), .powered_out(pwr));
   // ----------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      addr <= a;
      wdata <= v & ~32'h0004_0000;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task rd_reg(input logic [7:0] a);
      @(posedge clock_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task count_pulses(input logic [31:0] v);
      n1 = 0;
      n2 = 0;
      n3 = 0;
      wr_reg(CTRL_OFFSET, v);
      repeat (10) begin
         n1 += irq;
         n2 += swr;
         n3 += prst && link;
         @(posedge clock_in);
         #1;
      end
   endtask : count_pulses
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task test_pulses;
      rd_reg(CTRL_OFFSET);
      check("ctrl reset", d, CTRL_RESET);
      count_pulses(32'h8600_0000);
      check("irq len", n1, 4);
      check("host_software_reset len", n2, 4);
      check("rst no permit", n3, 0);
      rd_reg(CTRL_OFFSET);
      check("self clear", d, CTRL_RESET);
      wr_reg(SEMA_OFFSET, 32'h0000_0001);
      count_pulses(32'h8400_0000);
      check("rst len", n3, 1);
      check("phy resets", resets, 8'h01);
   endtask : test_pulses
   task test_power;
      wr_reg(CTRL_OFFSET, 32'h0001_0000);
      check("pin ovr 0", pin, 1'b0);
      wr_reg(CTRL_OFFSET, 32'h0003_0000);
      check("pin ovr 1", pin, 1'b1);
      wr_reg(CTRL_OFFSET, 32'h0000_0000);
      check("pd internal", {pin, pd}, 2'b11);
      wr_reg(CTRL_OFFSET, 32'h0100_0000);
      check("pd no enable", pd, 1'b0);
      @(posedge clock_in);
      ext_pd <= 1'b1;
      #1;
      check("pd cmd", {pin, pd, pwr}, 3'b010);
      rd_reg(STATE_OFFSET);
      check("state word", d, 32'h0000_0004);
      rd_reg(SEMA_OFFSET);
      check("permit read", d, 32'h0000_0001);
   endtask : test_power
   task test_mac;
      wr_reg(CTRL_OFFSET, 32'h5800_0000);
      check("mac bits", mac, 3'b111);
      rd_reg(CTRL_OFFSET);
      check("mac read", d, 32'h5810_0000);
      @(posedge clock_in);
      an_ld <= 1'b1;
      @(posedge clock_in);
      an_ld <= 1'b0;
      #1;
      check("autoneg", mac, 3'b101);
      rd_reg(8'h0C);
      check("unmapped", d, 32'h0000_0000);
   endtask : test_mac
   task test_freeze;
      @(posedge clock_in);
      en <= 1'b0;
      wr_reg(CTRL_OFFSET, 32'h0000_0000);
      check("frozen mac", mac, 3'b101);
      @(posedge clock_in);
      en <= 1'b1;
      rd_reg(CTRL_OFFSET);
      check("frozen ctrl", d, 32'h4810_0000);
   endtask : test_freeze
   task results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   initial begin
      repeat (3000) @(posedge clock_in);
      mismatches++;
      results();
   end
   initial begin
      {srst_in, wr, rd, ext_pd, int_pd, int_lvl, an_ld, an_rx, an_tx, en} = 10'h235;
      {addr, wdata, mismatches, checked} = '0;
      repeat (4) @(posedge clock_in);
      srst_in <= 1'b0;
      test_pulses();
      test_power();
      test_mac();
      test_freeze();
      results();
   end
endmodule : device_control_upper_bits_tb
